/* File: common/seecc_pkg.sv */
package seecc_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int TMO_MS = 30;
    localparam int TMO_CYC = (CLK_HZ / 1000) * TMO_MS;
    localparam int SK_HALF_CYC = 4;
    localparam int READY_SETTLE_CYC = 3;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int BUS_AW = 8;
    localparam logic [7:0] REG_CMD = 8'hB0;
    localparam logic [7:0] REG_DATA = 8'hB4;
    localparam logic [7:0] REG_IRQ_STAT = 8'hB8;
    localparam logic [7:0] REG_IRQ_MASK = 8'hBC;

    localparam int BUSY_BIT = 31;
    localparam int CMD_LSB = 28;
    localparam int CMD_W = 3;
    localparam int TMO_BIT = 9;
    localparam int LOADED_BIT = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    localparam int IRQ_W = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_TMO = 1;
    localparam int IRQ_LOADED = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    // ****************************************************************
    // Commands and serial frame
    // ****************************************************************
    typedef enum logic [2:0] {
        CMD_READ = 3'h0,
        CMD_EWDS = 3'h1,
        CMD_EWEN = 3'h2,
        CMD_WRITE = 3'h3,
        CMD_WRITE_ALL_CMD = 3'h4,
        CMD_ERASE = 3'h5,
        CMD_ERASE_ALL_CMD = 3'h6,
        CMD_RELOAD = 3'h7
    } seecc_cmd_t;

    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [7:0] EXT_EWEN = 8'hC0;
    localparam logic [7:0] EXT_EWDS = 8'h00;
    localparam logic [7:0] EXT_ERASE_ALL_CMD = 8'h80;
    localparam logic [7:0] EXT_WRITE_ALL_CMD = 8'h40;
    localparam int FRAME_W = 19;
    localparam int HDR_LEN = 11;
    localparam int PROG_LEN = 19;
    localparam int RD_LEN = 9;
    localparam int BITCNT_W = 5;

    localparam int RELOAD_BYTES = 7;
    localparam int MAC_W = 48;
    // Signature value is arbitrary
    localparam logic [7:0] SIG_VALUE = 8'h5A;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [BUS_AW-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } seecc_bus_req_t;

    typedef struct packed {
        logic cs;
        logic sk;
        logic dout;
        logic dout_oe_n;
    } seecc_pin_out_t;

endpackage

/* File: rtl/seecc_sync.sv */
`timescale 1ns/1ps
module seecc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // ****************************************************************
    // Two-stage synchroniser
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

/* File: rtl/seecc_ctrl.sv */
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module seecc_ctrl
    import seecc_pkg::*;
#(
    parameter int TIMEOUT_CYC = seecc_pkg::TMO_CYC,
    parameter int SK_HALF = seecc_pkg::SK_HALF_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire seecc_pkg::seecc_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    // Serial memory pins
    output seecc_pkg::seecc_pin_out_t eeprom_pins,
    input wire logic eeprom_serial_data_pin,
    // Status
    output logic [seecc_pkg::MAC_W-1:0] station_addr,
    output logic irq
);
    import seecc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SHIFT = 3'h1,
        ST_READ = 3'h2,
        ST_GAP = 3'h3,
        ST_WAIT = 3'h4,
        ST_FINISH = 3'h5
    } seecc_state_t;

    localparam int TMO_CW = $clog2(TIMEOUT_CYC + 1);
    localparam int DIV_W = $clog2(SK_HALF + 1);
    localparam logic [TMO_CW-1:0] TMO_LAST = TMO_CW'(TIMEOUT_CYC - 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SK_HALF - 1);
    localparam logic [2:0] RELOAD_LAST = 3'(RELOAD_BYTES - 1);
    // Pin sync depth plus memory response before ready status is trusted
    localparam logic [TMO_CW-1:0] READY_SETTLE = TMO_CW'(READY_SETTLE_CYC);

    seecc_state_t state_r;
    logic [DIV_W-1:0] div_r;
    logic tick;
    logic pin_s;
    logic [FRAME_W-1:0] sh_r;
    logic [BITCNT_W-1:0] cnt_r;
    logic [DATA_W-1:0] rx_r;
    logic [DATA_W-1:0] rx_nxt;
    logic [TMO_CW-1:0] tmo_r;
    logic cs_r;
    logic sk_r;
    logic oe_n_r;
    seecc_cmd_t op_r;
    seecc_cmd_t cmd_field_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] data_r;
    logic ew_en_r;
    logic tmo_flag_r;
    logic loaded_r;
    logic reload_pend_r;
    logic reload_act_r;
    logic [2:0] byte_idx_r;
    logic sig_ok_r;
    logic [MAC_W-1:0] station_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [31:0] rdata_r;
    logic done_p_r;
    logic tmo_p_r;
    logic rd_p_r;
    logic load_ok_p_r;
    logic busy;
    logic sw_go;
    logic go;
    seecc_cmd_t go_op;
    logic [ADDR_W-1:0] go_addr;
    logic go_prog;
    logic [FRAME_W-1:0] go_frame;
    logic [BITCNT_W-1:0] go_len;

    // ****************************************************************
    // Serial clock divider and pin input
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n || div_r == DIV_LAST) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end
    assign tick = (div_r == DIV_LAST);

    seecc_sync #(
        .W(1)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in(eeprom_serial_data_pin),
        .sync_out(pin_s)
    );

    // ****************************************************************
    // Command launch
    // ****************************************************************
    assign busy = (state_r != ST_IDLE) || reload_pend_r || reload_act_r;
    assign sw_go = bus_req.wr && bus_req.addr == REG_CMD && bus_req.wdata[BUSY_BIT] && !busy;
    assign go = (state_r == ST_IDLE)
        && (reload_pend_r || reload_act_r || (sw_go && go_op != CMD_RELOAD));
    assign rx_nxt = {rx_r[DATA_W-2:0], pin_s};

    always_comb begin
        if (reload_pend_r || reload_act_r) begin
            go_op = CMD_READ;
            go_addr = {5'h00, byte_idx_r};
        end else begin
            go_op = seecc_cmd_t'(bus_req.wdata[CMD_LSB +: CMD_W]);
            go_addr = bus_req.wdata[ADDR_W-1:0];
        end
        go_prog = (go_op == CMD_WRITE) || (go_op == CMD_WRITE_ALL_CMD)
            || (go_op == CMD_ERASE) || (go_op == CMD_ERASE_ALL_CMD);
        go_len = BITCNT_W'(HDR_LEN);
        case (go_op)
            CMD_READ, CMD_RELOAD: begin
                go_frame = {1'b1, OP_READ, go_addr, DATA_RST};
            end
            CMD_WRITE: begin
                go_frame = {1'b1, OP_WRITE, go_addr, data_r};
                go_len = BITCNT_W'(PROG_LEN);
            end
            CMD_WRITE_ALL_CMD: begin
                go_frame = {1'b1, OP_EXT, EXT_WRITE_ALL_CMD, data_r};
                go_len = BITCNT_W'(PROG_LEN);
            end
            CMD_ERASE: begin
                go_frame = {1'b1, OP_ERASE, go_addr, DATA_RST};
            end
            CMD_ERASE_ALL_CMD: begin
                go_frame = {1'b1, OP_EXT, EXT_ERASE_ALL_CMD, DATA_RST};
            end
            CMD_EWEN: begin
                go_frame = {1'b1, OP_EXT, EXT_EWEN, DATA_RST};
            end
            default: begin
                go_frame = {1'b1, OP_EXT, EXT_EWDS, DATA_RST};
            end
        endcase
    end

    // ****************************************************************
    // Serial sequencer
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            sh_r <= '0;
            cnt_r <= '0;
            rx_r <= DATA_RST;
            tmo_r <= '0;
            cs_r <= 1'b0;
            sk_r <= 1'b0;
            oe_n_r <= 1'b1;
            op_r <= CMD_READ;
            done_p_r <= 1'b0;
            tmo_p_r <= 1'b0;
            rd_p_r <= 1'b0;
        end else begin
            done_p_r <= 1'b0;
            tmo_p_r <= 1'b0;
            rd_p_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (go) begin
                        op_r <= go_op;
                        sh_r <= go_frame;
                        cnt_r <= go_len;
                        sk_r <= 1'b0;
                        if (go_prog && !ew_en_r) begin
                            state_r <= ST_FINISH;
                        end else begin
                            cs_r <= 1'b1;
                            oe_n_r <= 1'b0;
                            state_r <= ST_SHIFT;
                        end
                    end
                end
                ST_SHIFT: begin
                    if (tick) begin
                        sk_r <= !sk_r;
                        if (sk_r) begin
                            sh_r <= {sh_r[FRAME_W-2:0], 1'b0};
                            cnt_r <= cnt_r - 1'b1;
                            if (cnt_r == BITCNT_W'(1)) begin
                                oe_n_r <= 1'b1;
                                if (op_r == CMD_READ || op_r == CMD_RELOAD) begin
                                    cnt_r <= BITCNT_W'(RD_LEN);
                                    state_r <= ST_READ;
                                end else if (op_r == CMD_WRITE || op_r == CMD_WRITE_ALL_CMD
                                    || op_r == CMD_ERASE || op_r == CMD_ERASE_ALL_CMD) begin
                                    cs_r <= 1'b0;
                                    state_r <= ST_GAP;
                                end else begin
                                    state_r <= ST_FINISH;
                                end
                            end
                        end
                    end
                end
                ST_READ: begin
                    if (tick) begin
                        sk_r <= !sk_r;
                        if (sk_r) begin
                            rx_r <= rx_nxt;
                            cnt_r <= cnt_r - 1'b1;
                            if (cnt_r == BITCNT_W'(1)) begin
                                rd_p_r <= 1'b1;
                                state_r <= ST_FINISH;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    if (tick) begin
                        cs_r <= 1'b1;
                        tmo_r <= '0;
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (pin_s && tmo_r >= READY_SETTLE) begin
                        state_r <= ST_FINISH;
                    end else if (tmo_r == TMO_LAST) begin
                        tmo_p_r <= 1'b1;
                        state_r <= ST_FINISH;
                    end else begin
                        tmo_r <= tmo_r + 1'b1;
                    end
                end
                default: begin
                    cs_r <= 1'b0;
                    sk_r <= 1'b0;
                    oe_n_r <= 1'b1;
                    done_p_r <= 1'b1;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Erase/write enable latch
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ew_en_r <= 1'b0;
        end else if (go && go_op == CMD_EWEN) begin
            ew_en_r <= 1'b1;
        end else if (go && go_op == CMD_EWDS) begin
            ew_en_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Station address reload
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reload_pend_r <= 1'b1;
            reload_act_r <= 1'b0;
            byte_idx_r <= '0;
            sig_ok_r <= 1'b0;
            station_r <= '0;
            load_ok_p_r <= 1'b0;
        end else begin
            load_ok_p_r <= 1'b0;
            if (sw_go && bus_req.wdata[CMD_LSB +: CMD_W] == CMD_RELOAD) begin
                reload_pend_r <= 1'b1;
            end else if (go && reload_pend_r) begin
                reload_pend_r <= 1'b0;
                reload_act_r <= 1'b1;
                byte_idx_r <= '0;
            end
            if (reload_act_r && rd_p_r) begin
                if (byte_idx_r == '0) begin
                    sig_ok_r <= (rx_r == SIG_VALUE);
                end else begin
                    station_r <= {rx_r, station_r[MAC_W-1:DATA_W]};
                end
                if (byte_idx_r == RELOAD_LAST) begin
                    reload_act_r <= 1'b0;
                    load_ok_p_r <= sig_ok_r;
                end else begin
                    byte_idx_r <= byte_idx_r + 1'b1;
                end
            end
        end
    end
    assign station_addr = station_r;

    // ****************************************************************
    // Command register fields
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            addr_r <= ADDR_RST;
            cmd_field_r <= CMD_READ;
        end else if (sw_go) begin
            addr_r <= bus_req.wdata[ADDR_W-1:0];
            cmd_field_r <= go_op;
        end else if (bus_req.wr && bus_req.addr == REG_CMD && !busy) begin
            addr_r <= bus_req.wdata[ADDR_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tmo_flag_r <= 1'b0;
            loaded_r <= 1'b0;
        end else begin
            if (tmo_p_r) begin
                tmo_flag_r <= 1'b1;
            end else if (bus_req.wr && bus_req.addr == REG_CMD && bus_req.wdata[TMO_BIT]) begin
                tmo_flag_r <= 1'b0;
            end
            if (load_ok_p_r) begin
                loaded_r <= 1'b1;
            end else if (bus_req.wr && bus_req.addr == REG_CMD
                && bus_req.wdata[LOADED_BIT]) begin
                loaded_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Data register
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            data_r <= DATA_RST;
        end else if (rd_p_r && !reload_act_r) begin
            data_r <= rx_r;
        end else if (bus_req.wr && bus_req.addr == REG_DATA && !busy) begin
            data_r <= bus_req.wdata[DATA_W-1:0];
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            irq_stat_r <= IRQ_RST;
            irq_mask_r <= IRQ_RST;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                if (bus_req.rd && bus_req.addr == REG_IRQ_STAT) begin
                    irq_stat_r[i] <= 1'b0;
                end
            end
            if (done_p_r) begin
                irq_stat_r[IRQ_DONE] <= 1'b1;
            end
            if (tmo_p_r) begin
                irq_stat_r[IRQ_TMO] <= 1'b1;
            end
            if (load_ok_p_r) begin
                irq_stat_r[IRQ_LOADED] <= 1'b1;
            end
            if (bus_req.wr && bus_req.addr == REG_IRQ_MASK) begin
                irq_mask_r <= bus_req.wdata[IRQ_W-1:0];
            end
        end
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rdata_r <= '0;
        end else if (bus_req.rd) begin
            if (bus_req.addr == REG_CMD) begin
                rdata_r <= '0;
                rdata_r[BUSY_BIT] <= busy;
                rdata_r[CMD_LSB +: CMD_W] <= cmd_field_r;
                rdata_r[TMO_BIT] <= tmo_flag_r;
                rdata_r[LOADED_BIT] <= loaded_r;
                rdata_r[ADDR_W-1:0] <= addr_r;
            end else if (bus_req.addr == REG_DATA) begin
                rdata_r <= {24'h000000, data_r};
            end else if (bus_req.addr == REG_IRQ_STAT) begin
                rdata_r <= {29'h00000000, irq_stat_r};
            end else if (bus_req.addr == REG_IRQ_MASK) begin
                rdata_r <= {29'h00000000, irq_mask_r};
            end else begin
                rdata_r <= '0;
            end
        end else begin
            rdata_r <= '0;
        end
    end
    assign bus_rdata = rdata_r;

    // ****************************************************************
    // Pin outputs
    // ****************************************************************
    assign eeprom_pins.cs = cs_r;
    assign eeprom_pins.sk = sk_r;
    assign eeprom_pins.dout = sh_r[FRAME_W-1];
    assign eeprom_pins.dout_oe_n = oe_n_r;
endmodule

/* File: bench/seecc_ctrl_monitor.sv */
`timescale 1ns/1ps
module seecc_ctrl_monitor #(
    parameter int TIMEOUT_CYC = 750000,
    parameter int SK_HALF = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire seecc_pkg::seecc_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    // Serial memory pins
    input wire seecc_pkg::seecc_pin_out_t eeprom_pins,
    input wire logic eeprom_serial_data_pin,
    // Status
    input wire logic [seecc_pkg::MAC_W-1:0] station_addr,
    input wire logic irq
);
    import seecc_pkg::*;
    logic [2:0] mask_r;
    logic sk_r;
    logic tmo_r;
    int hi_r;
    int stall_r;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mask_r <= 3'h0;
            tmo_r <= 1'b0;
        end else begin
            if (bus_req.wr && bus_req.addr == REG_IRQ_MASK) begin
                mask_r <= bus_req.wdata[2:0];
            end
            if (stall_r == TIMEOUT_CYC - 8) begin
                tmo_r <= 1'b1;
            end else if (bus_req.wr && bus_req.addr == REG_CMD && bus_req.wdata[9]) begin
                tmo_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        sk_r <= eeprom_pins.sk;
        hi_r <= (reset_n && eeprom_pins.sk) ? hi_r + 1 : 0;
        stall_r <= (reset_n && eeprom_pins.cs && eeprom_pins.sk == sk_r) ? stall_r + 1 : 0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_read(a);
        bus_req.rd && bus_req.addr == a;
    endsequence
    sequence s_ready;
        (stall_r > 2 * SK_HALF && eeprom_pins.dout_oe_n && eeprom_serial_data_pin)[*3];
    endsequence
    sequence s_tmo_settled;
        (tmo_r && !eeprom_pins.cs)[*3];
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0)
        !reset_n |=> !eeprom_pins.cs && eeprom_pins.dout_oe_n) else $error("pins busy in reset");
    a_rdata_one_cycle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_stat_irq: assert property (s_read(REG_IRQ_STAT) |=>
        (|(bus_rdata[2:0] & $past(mask_r))) == $past(irq)) else $error("irq not status and mask");
    a_sk_in_frame: assert property (eeprom_pins.sk |-> eeprom_pins.cs)
        else $error("serial clock outside frame");
    a_sk_high_len: assert property ($fell(eeprom_pins.sk) |-> hi_r == SK_HALF)
        else $error("serial clock high phase length");
    a_wait_bounded: assert property (stall_r <= TIMEOUT_CYC + 8)
        else $error("wait exceeds time-out");
    a_ready_ends_wait: assert property (s_ready |-> ##[0:6] !eeprom_pins.cs)
        else $error("ready pin did not end wait");
    a_tmo_flag_read: assert property (s_tmo_settled ##0 s_read(REG_CMD) |=> bus_rdata[9])
        else $error("time-out flag not set");
endmodule
bind seecc_ctrl seecc_ctrl_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC), .SK_HALF(SK_HALF)) u_monitor (
    .clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .eeprom_pins(eeprom_pins), .eeprom_serial_data_pin(eeprom_serial_data_pin),
    .station_addr(station_addr), .irq(irq));

/* File: bench/seecc_eeprom_model.sv */
`timescale 1ns/1ps
module seecc_eeprom_model #(
    parameter int BUSY_CYC = 40
) (
    // Clock
    input wire logic clk_sys,
    // Pins; mode 0 present, 1 absent pulled high, 2 absent pulled low
    input wire seecc_pkg::seecc_pin_out_t pins,
    input wire logic [1:0] mode,
    output logic pin_out
);
    import seecc_pkg::*;
    logic [7:0] mem [256];
    logic [18:0] sh_r;
    logic [9:0] out_r;
    logic [4:0] cnt_r = 5'h0;
    int busy_r = 0;
    logic sk_r = 1'b0, cs_r = 1'b0, rd_r = 1'b0, prog_r = 1'b0, rdy_r = 1'b0, tog_r = 1'b0;
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'hFF;
        end
        mem[0] = SIG_VALUE;
        for (int i = 1; i < 7; i++) begin
            mem[i] = 8'(8'h10 + i);
        end
    end
    always @(posedge clk_sys) begin
        sk_r <= pins.sk;
        cs_r <= pins.cs;
        tog_r <= ~tog_r;
        busy_r <= (busy_r > 0) ? busy_r - 1 : 0;
        if (pins.cs && pins.sk && !sk_r && !rd_r) begin
            sh_r <= {sh_r[17:0], pins.dout};
            cnt_r <= cnt_r + 5'h1;
        end
        if (pins.cs && !pins.sk && sk_r && rd_r) begin
            out_r <= {out_r[8:0], 1'b1};
        end
        if (pins.cs && cnt_r == 5'd11 && sh_r[9:8] == OP_READ && !rd_r) begin
            rd_r <= 1'b1;
            out_r <= {2'b00, mem[sh_r[7:0]]};
        end
        if (pins.cs && !cs_r && prog_r) begin
            busy_r <= BUSY_CYC;
            rdy_r <= 1'b1;
            prog_r <= 1'b0;
        end
        if (!pins.cs && cs_r) begin
            prog_r <= (cnt_r == 5'd19 && (sh_r[17:16] == OP_WRITE || sh_r[15:8] == EXT_WRITE_ALL_CMD))
                || (cnt_r == 5'd11 && (sh_r[9:8] == OP_ERASE || sh_r[7:0] == EXT_ERASE_ALL_CMD));
            if (cnt_r == 5'd19 && sh_r[17:16] == OP_WRITE) begin
                mem[sh_r[15:8]] <= sh_r[7:0];
            end
        end
        if (!pins.cs) begin
            cnt_r <= 5'h0;
            rd_r <= 1'b0;
            rdy_r <= 1'b0;
        end
    end
    always_comb begin
        if (mode != 2'h0) pin_out = (mode == 2'h1);
        else if (rd_r) pin_out = out_r[9];
        else if (rdy_r) pin_out = (busy_r == 0);
        else pin_out = tog_r;
    end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
    import seecc_pkg::*;
    localparam int TMO = 200;
    logic clk_sys;
    logic reset_n;
    seecc_bus_req_t bus_req;
    logic [31:0] bus_rdata;
    seecc_pin_out_t eeprom_pins;
    logic [47:0] station_addr;
    logic irq;
    logic model_pin;
    logic [1:0] mem_mode;
    logic [31:0] v;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    wire logic data_pin = eeprom_pins.dout_oe_n ? model_pin : eeprom_pins.dout;
    seecc_ctrl #(.TIMEOUT_CYC(TMO), .SK_HALF(4)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .eeprom_pins(eeprom_pins),
        .eeprom_serial_data_pin(data_pin), .station_addr(station_addr), .irq(irq));
    seecc_eeprom_model u_mem (.clk_sys(clk_sys), .pins(eeprom_pins), .mode(mem_mode),
        .pin_out(model_pin));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic test_done();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            test_done();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        @(posedge clk_sys);
        v = bus_rdata;
    endtask
    task automatic expect_reg(input string name, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        rd(a);
        chk(name, v & m, e);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        rd(REG_CMD);
        while (v[BUSY_BIT] !== 1'b0 && n < 2000) begin
            rd(REG_CMD);
            n++;
        end
        if (n >= 2000) begin
            errors++;
            test_done();
        end
    endtask
    task automatic cmd(input logic [2:0] c, input logic [7:0] a);
        wr(REG_CMD, {1'b1, c, 20'h0, a});
        wait_idle();
    endtask
    task automatic power_up();
        reset_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        wait_idle();
        chk("cmd_reg", v & 32'h8000_03FF, 32'h0000_0100);
    endtask
    initial begin
        bus_req = '0;
        reset_n = 1'b0;
        mem_mode = 2'h0;
        power_up();
        chk("station_lo", station_addr[31:0], 32'h1413_1211);
        chk("station_hi", {16'h0, station_addr[47:32]}, 32'h1615);
        expect_reg("irq_stat", REG_IRQ_STAT, 32'hFFFF_FFFF, 32'h5);
        expect_reg("stat_clear", REG_IRQ_STAT, 32'hFFFF_FFFF, 32'h0);
        expect_reg("unmapped", 8'hC0, 32'hFFFF_FFFF, 32'h0);
        wr(REG_DATA, 32'h1234_56A5);
        expect_reg("data_reg", REG_DATA, 32'hFFFF_FFFF, 32'hA5);
        cmd(CMD_WRITE, 8'h20);
        cmd(CMD_READ, 8'h20);
        expect_reg("locked", REG_DATA, 32'hFF, 32'hFF);
        cmd(CMD_EWEN, 8'h00);
        wr(REG_DATA, 32'hA5);
        cmd(CMD_WRITE, 8'h20);
        cmd(CMD_READ, 8'h20);
        chk("addr_field", v & 32'hFF, 32'h20);
        expect_reg("written", REG_DATA, 32'hFF, 32'hA5);
        cmd(CMD_EWDS, 8'h00);
        wr(REG_DATA, 32'h5C);
        cmd(CMD_WRITE, 8'h20);
        cmd(CMD_READ, 8'h20);
        expect_reg("disabled", REG_DATA, 32'hFF, 32'hA5);
        wr(REG_CMD, {1'b1, CMD_READ, 20'h0, 8'h30});
        wr(REG_CMD, {1'b1, CMD_WRITE, 20'h0, 8'h31});
        wait_idle();
        chk("busy_ignore", v & 32'hFF, 32'h30);
        mem_mode <= 2'h1;
        wr(REG_IRQ_MASK, 32'h1);
        cmd(CMD_EWEN, 8'h00);
        cmd(CMD_WRITE, 8'h40);
        chk("no_timeout", v & 32'h200, 32'h0);
        chk("irq_on", {31'h0, irq}, 32'h1);
        expect_reg("stat_done", REG_IRQ_STAT, 32'h3, 32'h1);
        chk("irq_off", {31'h0, irq}, 32'h0);
        mem_mode <= 2'h2;
        wr(REG_CMD, 32'h300);
        for (int c = 0; c < 8; c++) begin
            cmd(3'(c), 8'h50);
            chk("timeout_flag", v & 32'h200, (c > 2 && c < 7) ? 32'h200 : 32'h0);
            wr(REG_CMD, 32'h200);
        end
        expect_reg("flag_cleared", REG_CMD, 32'h300, 32'h0);
        mem_mode <= 2'h0;
        cmd(CMD_EWEN, 8'h00);
        power_up();
        wr(REG_DATA, 32'h33);
        cmd(CMD_WRITE, 8'h21);
        cmd(CMD_READ, 8'h21);
        expect_reg("relocked", REG_DATA, 32'hFF, 32'hFF);
        test_done();
    end
endmodule
